// >>> pkg/scb_pkg.sv
// Constants for the serial clock and buffer configuration block.
// Assumes one system clock and a plain register port with byte addresses.
`default_nettype none
package scb_pkg;
   // Register byte offsets.
   localparam logic [7:0] MODE_ZERO_OFS   = 8'h00;
   localparam logic [7:0] BAUD_CTRL_OFS   = 8'h04;
   localparam logic [7:0] BAUD_FRAC_OFS   = 8'h08;
   localparam logic [7:0] CHAN_CTRL_OFS   = 8'h0C;
   localparam logic [7:0] MODE_ONE_OFS    = 8'h10;
   localparam logic [7:0] MODE_TWO_OFS    = 8'h14;
   localparam logic [7:0] FIFO_CFG_OFS    = 8'h18;
   localparam logic [7:0] TX_FIFO_CTL_OFS = 8'h1C;
   localparam logic [7:0] TIMER_CMP_OFS   = 8'h20;
   localparam logic [7:0] STATUS_OFS      = 8'h24;
   localparam logic [7:0] TX_DATA_OFS     = 8'h28;
   // Field positions.
   localparam int MODE_SEL_POS   = 0;  // serial_mode_sel, 2 bits
   localparam int CLK_SRC_POS    = 2;  // uart_clock_source, 2 bits
   localparam int BRS_POS        = 0;  // divide by N, 4 bits
   localparam int BRCK_POS       = 4;  // generator input tap, 2 bits
   localparam int FRAC_EN_POS    = 6;  // divide-function bit
   localparam int TAP_SEL_POS    = 7;  // tap select bit
   localparam int BRK_POS        = 0;  // fraction K, 4 bits
   localparam int IO_CLK_IN_POS  = 0;  // 1 = clock-input mode
   localparam int EDGE_SEL_POS   = 1;  // clock-input edge select
   localparam int DUPLEX_POS     = 0;  // duplex field, 2 bits
   localparam int WBUF_POS       = 0;  // double buffer bit
   localparam int TX_RUN_POS     = 1;  // transmit_running, read only
   localparam int EMPTY_POS      = 2;  // buffer_empty_flag, read only
   localparam int CNFG_POS       = 0;  // FIFO configure bit
   localparam int TRANSMIT_BUFFER_CLEAR_POS      = 0;  // transmit_buffer_clear, write one
   localparam int TFCLR_POS      = 1;  // transmit FIFO clear, write one
   localparam int RFCLR_POS      = 2;  // receive FIFO clear, write one
   // Encodings.
   localparam logic [1:0] MODE_IO       = 2'h0;
   localparam logic [1:0] SRC_TIMER     = 2'h0;
   localparam logic [1:0] SRC_BRG       = 2'h1;
   localparam logic [1:0] SRC_SYSCLK    = 2'h2;
   localparam logic [1:0] SRC_PIN       = 2'h3;
   localparam logic [1:0] DPX_HALF_RX   = 2'h1;
   localparam logic [1:0] DPX_HALF_TX   = 2'h2;
   localparam logic [1:0] DPX_FULL      = 2'h3;
   localparam logic [2:0] FIFO_DEPTH    = 3'h4;
   localparam logic [2:0] FIFO_HALF     = 3'h2;
   localparam logic [3:0] UART_DIV_LAST = 4'hF;
   localparam logic [4:0] FRAC_ONE      = 5'h10;
   localparam logic [4:0] N_ZERO_MEANS  = 5'h10;
   // Reset values.
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
endpackage
`default_nettype wire

// >>> verification/scb_serial_peer.sv
// Serial peer model: drives the clock pin in clock-input modes.
// Assumes the system clock; the pin rests high between frames.
`default_nettype none
module scb_serial_peer (
   input  wire logic clk,  // System clock.
   input  wire logic run,  // Frame in progress.
   output var  logic sclk  // Clock to the pin.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] cnt;
   // Ten-cycle period stays clear of the minimum; no edges outside frames.
   always @(posedge clk) begin
      cnt <= (!run || cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
      if (!run)
         sclk <= 1'b1;
      else if (cnt == 3'h4)
         sclk <= !sclk;
   end
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the serial clock and buffer block.
// Assumes the package register map and the serial peer model.
`default_nettype none
module tb import scb_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst_n, regWr, regRd, transmit_running, shLoad, peerRun, peerClk, pin;
   logic        txBufValid, sOut, sOe, bitTick, txStb, rxStb;
   logic [7:0]  regAddr, txBufData;
   logic [31:0] regWdata, regRdata, d;
   int          fail_count, checked, n;
   // The pin is driven by whichever side has it enabled.
   assign pin = sOe ? sOut : peerClk;
   scb_clock_buffer dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .transmitRunning(transmit_running),
      .txShiftLoad(shLoad), .txBufData(txBufData), .txBufValid(txBufValid),
      .serialClockIn(pin), .serialClockOut(sOut), .serialClockOe(sOe), .uartBitTick(bitTick),
      .ioTxStrobe(txStb), .ioRxStrobe(rxStb), .transferClock(), .txDouble(), .rxDouble(),
      .fifoEnable());
   scb_serial_peer peer (.clk(clk), .run(peerRun), .sclk(peerClk));
   task automatic check(input string nm, input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      regAddr <= a;
      regWdata <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask
   // Cycles between the first two pulses of one strobe; 0 if fewer than two.
   task automatic gap(input int i, output int g);
      int t0;
      logic [2:0] w;
      t0 = -1;
      g = 0;
      for (int c = 0; c < 200; c++) begin
         @(posedge clk);
         #1 w = {bitTick, rxStb, txStb};
         if (w[i] && t0 >= 0 && g == 0)
            g = c - t0;
         if (w[i] && t0 < 0)
            t0 = c;
      end
   endtask
   task automatic buffers();
      rd(8'hFC);
      check("unmapped", d, 32'h0);
      rd(MODE_TWO_OFS);
      check("empty flag", d, 32'h4);
      wr(MODE_TWO_OFS, 32'h1);
      wr(FIFO_CFG_OFS, 32'h1);
      wr(MODE_ONE_OFS, 32'h2);
      wr(TX_FIFO_CTL_OFS, 32'h6);
      rd(STATUS_OFS);
      check("status", {d[6:4], d[2:0]}, 32'h27);
      wr(TX_DATA_OFS, 32'hAB);
      wr(TX_DATA_OFS, 32'h11);
      wr(TX_DATA_OFS, 32'h22);
      check("buffer", txBufData, 32'hAB);
      wr(TX_FIFO_CTL_OFS, 32'h1);
      @(posedge clk);
      #1 check("refill", txBufData, 32'h11);
      @(posedge clk);
      shLoad <= 1'b1;
      @(posedge clk);
      shLoad <= 1'b0;
      @(posedge clk);
      #1 check("load", txBufData, 32'h22);
      wr(TX_FIFO_CTL_OFS, 32'h1);
      transmit_running <= 1'b1;
      rd(MODE_TWO_OFS);
      check("cleared", d, 32'h7);
      transmit_running <= 1'b0;
      wr(MODE_ONE_OFS, 32'h3);
      wr(TX_FIFO_CTL_OFS, 32'h6);
      rd(STATUS_OFS);
      check("full duplex", {d[10:8], d[6:4]}, 32'h12);
      wr(FIFO_CFG_OFS, 32'h0);
      rd(STATUS_OFS);
      check("fifo off", d[2], 32'h0);
   endtask
   task automatic clocks();
      logic [7:0] md[6];
      logic [7:0] br[6];
      int ix[6], ex[6];
      md = '{8'h04, 8'h04, 8'h05, 8'h09, 8'h01, 8'h00};
      br = '{8'h82, 8'h02, 8'hC2, 8'h82, 8'h82, 8'h82};
      ix = '{0, 0, 2, 2, 2, 0};
      ex = '{4, 8, 40, 16, 64, 0};
      wr(BAUD_FRAC_OFS, 32'h8);
      wr(TIMER_CMP_OFS, 32'h1);
      for (int k = 0; k < 6; k++) begin
         wr(BAUD_CTRL_OFS, {24'h0, br[k]});
         wr(MODE_ZERO_OFS, {24'h0, md[k]});
         gap(ix[k], n);
         check("gap", n, ex[k]);
      end
   endtask
   // Each strobe must see the pin already at the level of its chosen edge.
   task automatic clockIn();
      for (int e = 0; e < 2; e++) begin
         wr(CHAN_CTRL_OFS, 1 + 2 * e);
         peerRun <= 1'b1;
         n = 0;
         repeat (60) begin
            @(posedge clk);
            #1 n += txStb;
            if (txStb)
               check("tx edge", pin, e);
            if (rxStb)
               check("rx edge", pin, 1 - e);
         end
         peerRun <= 1'b0;
         check("strobes", n > 3, 1);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      {rst_n, regWr, regRd, regAddr, regWdata, transmit_running, shLoad, peerRun} = '0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      buffers();
      clocks();
      clockIn();
      complete_run();
   end
   // The tests need under 2000 cycles; a hang ends the run as a mismatch.
   initial begin
      #500000;
      fail_count++;
      complete_run();
   end
endmodule
`default_nettype wire

// >>> verilog/scb_clock_buffer.sv
// Serial channel clock generation and transmit buffer/FIFO configuration.
// Assumes all inputs synchronous to clk; a shifter outside consumes the transmit buffer.
//
// Our own choices: the placing of the registers and the strobed register port.
`default_nettype none
module scb_clock_buffer
   import scb_pkg::*;
#(
   parameter int TIMER_W = 16
)(
   input  wire  logic               clk,              // System clock, 20 MHz.
   input  wire  logic               rst_n,            // Synchronous reset, active low.
   input  wire  logic [7:0]         regAddr,          // Register byte address.
   input  wire  logic [31:0]        regWdata,         // Register write data.
   input  wire  logic               regWr,            // Write strobe.
   input  wire  logic               regRd,            // Read strobe.
   output logic       [31:0]        regRdata,         // Read data, cycle after strobe.
   input  wire  logic               transmitRunning,  // Shifter busy level.
   input  wire  logic               txShiftLoad,      // Shifter took the buffer, pulse.
   output logic       [7:0]         txBufData,        // Transmit buffer contents.
   output logic                     txBufValid,       // Transmit buffer holds data.
   input  wire  logic               serialClockIn,    // Serial clock pin input.
   output logic                     serialClockOut,   // Serial clock pin output.
   output logic                     serialClockOe,    // Serial clock pin drive enable.
   output logic                     uartBitTick,      // One bit time in UART mode.
   output logic                     ioTxStrobe,       // I/O mode shift-out edge.
   output logic                     ioRxStrobe,       // I/O mode sample edge.
   output logic                     transferClock,    // Selected transfer clock enable.
   output logic                     txDouble,         // Transmit double buffered.
   output logic                     rxDouble,         // Receive double buffered.
   output logic                     fifoEnable        // FIFO in use.
);
   // Configuration registers.
   logic [1:0]         serialModeSel_ff;
   logic [1:0]         uartClockSource_ff;
   logic [3:0]         brs_ff;
   logic [1:0]         brck_ff;
   logic               fracEn_ff;
   logic               tapSel_ff;
   logic [3:0]         brk_ff;
   logic               ioClkIn_ff;
   logic               edgeSel_ff;
   logic [1:0]         duplex_ff;
   logic               wbuf_ff;
   logic               cnfg_ff;
   logic [TIMER_W-1:0] timerCompare_ff;
   // Clock path state.
   logic [6:0]         pscCnt_ff;
   logic [4:0]         brgCnt_ff;
   logic [3:0]         fracAcc_ff;
   logic [TIMER_W-1:0] timerCnt_ff;
   logic               timerFlop_ff;
   logic               timerPrev_ff;
   logic               sclkOut_ff;
   logic               sclkPrev_ff;
   logic [3:0]         divCnt_ff;
   // Transmit buffer and FIFO state.
   logic [7:0]         txFifo_ff [4];
   logic [2:0]         txCount_ff;
   logic               rxFifoClr_ff;
   logic               wrTxData;
   logic               wrTbClr;
   logic               wrTfClr;

   // Exponent of the prescaler tap for a select bit and code.
   function automatic logic [2:0] tapExp(input logic sel, input logic [1:0] code);
      tapExp = sel ? {code, 1'b0} : {code, 1'b1};
   endfunction

   // FIFO bytes given to one direction by the duplex field.
   function automatic logic [2:0] fifoCap(input logic [1:0] dpx, input logic [1:0] full);
      if (dpx == DPX_FULL) begin
         fifoCap = FIFO_HALF;
      end else if (dpx == full) begin
         fifoCap = FIFO_DEPTH;
      end else begin
         fifoCap = 3'h0;
      end
   endfunction

   // Mode decode shared by clock and buffer logic.
   logic ioMode;
   logic ioOutMode;
   logic ioInMode;
   assign ioMode    = (serialModeSel_ff == MODE_IO);
   assign ioOutMode = ioMode && !ioClkIn_ff;
   assign ioInMode  = ioMode && ioClkIn_ff;
   assign txDouble   = wbuf_ff;
   assign rxDouble   = !ioOutMode || wbuf_ff;
   assign fifoEnable = wbuf_ff && cnfg_ff;
   logic [2:0] txCap;
   logic [2:0] rxCap;
   assign txCap = fifoEnable ? fifoCap(duplex_ff, DPX_HALF_TX) : 3'h0;
   assign rxCap = fifoEnable ? fifoCap(duplex_ff, DPX_HALF_RX) : 3'h0;

   // Register writes; the two transmit clear write-one bits are pulses decoded here and not stored.
   assign wrTxData = regWr && (regAddr == TX_DATA_OFS);
   assign wrTbClr  = regWr && (regAddr == TX_FIFO_CTL_OFS) && regWdata[TRANSMIT_BUFFER_CLEAR_POS];
   assign wrTfClr  = regWr && (regAddr == TX_FIFO_CTL_OFS) && regWdata[TFCLR_POS];
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         serialModeSel_ff   <= REG_RESET[1:0];
         uartClockSource_ff <= REG_RESET[1:0];
         brs_ff             <= REG_RESET[3:0];
         brck_ff            <= REG_RESET[1:0];
         fracEn_ff          <= REG_RESET[0];
         tapSel_ff          <= REG_RESET[0];
         brk_ff             <= REG_RESET[3:0];
         ioClkIn_ff         <= REG_RESET[0];
         edgeSel_ff         <= REG_RESET[0];
         duplex_ff          <= REG_RESET[1:0];
         wbuf_ff            <= REG_RESET[0];
         cnfg_ff            <= REG_RESET[0];
         timerCompare_ff    <= REG_RESET[TIMER_W-1:0];
      end else if (regWr) begin
         case (regAddr)
            MODE_ZERO_OFS: begin
               serialModeSel_ff   <= regWdata[MODE_SEL_POS +: 2];
               uartClockSource_ff <= regWdata[CLK_SRC_POS +: 2];
            end
            BAUD_CTRL_OFS: begin
               brs_ff    <= regWdata[BRS_POS +: 4];
               brck_ff   <= regWdata[BRCK_POS +: 2];
               fracEn_ff <= regWdata[FRAC_EN_POS];
               tapSel_ff <= regWdata[TAP_SEL_POS];
            end
            BAUD_FRAC_OFS: brk_ff <= regWdata[BRK_POS +: 4];
            CHAN_CTRL_OFS: begin
               ioClkIn_ff <= regWdata[IO_CLK_IN_POS];
               edgeSel_ff <= regWdata[EDGE_SEL_POS];
            end
            MODE_ONE_OFS:  duplex_ff <= regWdata[DUPLEX_POS +: 2];
            MODE_TWO_OFS:  wbuf_ff <= regWdata[WBUF_POS];
            FIFO_CFG_OFS:  cnfg_ff <= regWdata[CNFG_POS];
            TIMER_CMP_OFS: timerCompare_ff <= regWdata[TIMER_W-1:0];
            default: begin
            end
         endcase
      end
   end

   // Registered read port; unmapped addresses and reserved bits read zero.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         regRdata <= REG_RESET;
      end else begin
         regRdata <= REG_RESET;
         if (regRd) begin
            case (regAddr)
               MODE_ZERO_OFS: regRdata <= {28'h0, uartClockSource_ff, serialModeSel_ff};
               BAUD_CTRL_OFS: regRdata <= {24'h0, tapSel_ff, fracEn_ff, brck_ff, brs_ff};
               BAUD_FRAC_OFS: regRdata <= {28'h0, brk_ff};
               CHAN_CTRL_OFS: regRdata <= {30'h0, edgeSel_ff, ioClkIn_ff};
               MODE_ONE_OFS:  regRdata <= {30'h0, duplex_ff};
               MODE_TWO_OFS:  regRdata <= {29'h0, !txBufValid, transmitRunning, wbuf_ff};
               FIFO_CFG_OFS:  regRdata <= {31'h0, cnfg_ff};
               TIMER_CMP_OFS: regRdata <= 32'(timerCompare_ff);
               STATUS_OFS:    regRdata <= {16'h0, 1'b0, txCount_ff, 1'b0, rxCap,
                                           1'b0, txCap, rxFifoClr_ff, fifoEnable,
                                           rxDouble, txDouble};
               default:       regRdata <= REG_RESET;
            endcase
         end
      end
   end

   // Prescaler: free count only while the baud generator is the source, else held at zero
   // so that a later selection starts from a clean phase.
   logic prescalerOn;
   logic [6:0] tapMask;
   logic brgInTick;
   assign prescalerOn = (uartClockSource_ff == SRC_BRG);
   assign tapMask     = 7'((8'h01 << tapExp(tapSel_ff, brck_ff)) - 8'h01);
   assign brgInTick   = prescalerOn && ((pscCnt_ff & tapMask) == tapMask);
   always_ff @(posedge clk) begin
      if (!rst_n || !prescalerOn) begin
         pscCnt_ff <= 7'h00;
      end else begin
         pscCnt_ff <= pscCnt_ff + 7'h01;
      end
   end

   // Baud generator: N of zero means 16; fractional mode only in UART mode.
   logic [4:0] divN;
   logic [4:0] fracSum;
   logic       stretch;
   logic [4:0] period;
   logic       brgTick;
   logic       brgCfgWr;
   // A divider or mode change restarts the period, so a shorter period never finds
   // the counter already past its end.
   assign brgCfgWr = regWr && ((regAddr == BAUD_CTRL_OFS) || (regAddr == BAUD_FRAC_OFS) ||
                               (regAddr == MODE_ZERO_OFS));
   assign divN    = (brs_ff == 4'h0) ? N_ZERO_MEANS : {1'b0, brs_ff};
   assign fracSum = {1'b0, fracAcc_ff} + (FRAC_ONE - {1'b0, brk_ff});
   assign stretch = fracEn_ff && !ioMode && (fracSum >= FRAC_ONE);
   assign period  = divN + {4'h0, stretch};
   assign brgTick = brgInTick && (brgCnt_ff >= period - 5'h01);
   always_ff @(posedge clk) begin
      if (!rst_n || !prescalerOn || brgCfgWr) begin
         brgCnt_ff  <= 5'h00;
         fracAcc_ff <= 4'h0;
      end else if (brgTick) begin
         brgCnt_ff  <= 5'h00;
         fracAcc_ff <= (fracEn_ff && !ioMode) ? fracSum[3:0] : 4'h0;
      end else if (brgInTick) begin
         brgCnt_ff  <= brgCnt_ff + 5'h01;
      end
   end

   // Timer source: the flip-flop toggles at each compare match and the counter restarts.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         timerCnt_ff  <= '0;
         timerFlop_ff <= 1'b0;
         timerPrev_ff <= 1'b0;
      end else begin
         timerPrev_ff <= timerFlop_ff;
         if (timerCnt_ff == timerCompare_ff) begin
            timerCnt_ff  <= '0;
            timerFlop_ff <= !timerFlop_ff;
         end else begin
            timerCnt_ff  <= timerCnt_ff + 1'b1;
         end
      end
   end

   // External pin edges; the pin is already synchronous so one history flop suffices.
   // The history resets to the idle-high level so no false rising edge follows reset.
   logic pinRise;
   logic pinFall;
   assign pinRise = serialClockIn && !sclkPrev_ff;
   assign pinFall = !serialClockIn && sclkPrev_ff;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sclkPrev_ff <= 1'b1;
      end else begin
         sclkPrev_ff <= serialClockIn;
      end
   end

   // Clock-output mode: serial clock idles high and toggles at each generator tick.
   always_ff @(posedge clk) begin
      if (!rst_n || !ioOutMode) begin
         sclkOut_ff <= 1'b1;
      end else if (brgTick) begin
         sclkOut_ff <= !sclkOut_ff;
      end
   end
   assign serialClockOut = sclkOut_ff;
   assign serialClockOe  = ioOutMode;

   // I/O mode edges. Limitation: too-fast external clocks lose edges here.
   always_comb begin
      ioTxStrobe = 1'b0;
      ioRxStrobe = 1'b0;
      if (ioOutMode) begin
         ioTxStrobe = brgTick && sclkOut_ff;
         ioRxStrobe = brgTick && !sclkOut_ff;
      end else if (ioInMode) begin
         ioTxStrobe = edgeSel_ff ? pinRise : pinFall;
         ioRxStrobe = edgeSel_ff ? pinFall : pinRise;
      end
   end

   // UART transfer clock selection.
   always_comb begin
      case (uartClockSource_ff)
         SRC_TIMER:  transferClock = timerFlop_ff && !timerPrev_ff;
         SRC_BRG:    transferClock = brgTick;
         SRC_SYSCLK: transferClock = 1'b1;
         SRC_PIN:    transferClock = pinRise;
         default:    transferClock = 1'b0;
      endcase
      if (ioMode) begin
         transferClock = ioTxStrobe || ioRxStrobe;
      end
   end

   // Divide by 16 into bit time, as the transmit and receive counters do.
   assign uartBitTick = !ioMode && transferClock && (divCnt_ff == UART_DIV_LAST);
   always_ff @(posedge clk) begin
      if (!rst_n || ioMode) begin
         divCnt_ff <= 4'h0;
      end else if (transferClock) begin
         divCnt_ff <= divCnt_ff + 4'h1;
      end
   end

   // Transmit buffer with FIFO behind it. The buffer is refilled from the FIFO head
   // whenever it empties, so data order is kept across clears and shifter loads.
   logic txTake;
   logic txRefill;
   logic txPush;
   assign txTake   = txShiftLoad || wrTbClr;
   assign txRefill = txTake && (txCount_ff != 3'h0);
   assign txPush   = wrTxData && txBufValid && !txTake && (txCount_ff < txCap);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         txBufValid <= 1'b0;
         txBufData  <= 8'h00;
      end else if (txRefill) begin
         txBufValid <= 1'b1;
         txBufData  <= txFifo_ff[0];
      end else if (txTake) begin
         txBufValid <= 1'b0;
      end else if (wrTxData && !txBufValid) begin
         txBufValid <= 1'b1;
         txBufData  <= regWdata[7:0];
      end
   end

   // FIFO storage shifts toward entry zero on each refill; its count clears when disabled.
   always_ff @(posedge clk) begin
      if (!rst_n || !fifoEnable || wrTfClr) begin
         txCount_ff <= 3'h0;
      end else if (txRefill) begin
         txCount_ff <= txCount_ff - 3'h1;
      end else if (txPush) begin
         txCount_ff <= txCount_ff + 3'h1;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            txFifo_ff[i] <= 8'h00;
         end
      end else if (txRefill) begin
         for (int i = 0; i < 3; i++) begin
            txFifo_ff[i] <= txFifo_ff[i+1];
         end
      end else if (txPush) begin
         txFifo_ff[txCount_ff[1:0]] <= regWdata[7:0];
      end
   end

   // Receive FIFO clear is recorded so software can see the clear has been done.
   always_ff @(posedge clk) begin
      if (!rst_n || !fifoEnable) begin
         rxFifoClr_ff <= 1'b0;
      end else if (regWr && (regAddr == TX_FIFO_CTL_OFS) && regWdata[RFCLR_POS]) begin
         rxFifoClr_ff <= 1'b1;
      end
   end

   // Checks on the clock path, on the transmit buffer and FIFO logic, and on receive double buffering.
   a_prescale_idle: assert property (@(posedge clk) disable iff (!rst_n)
      (uartClockSource_ff != SRC_BRG) |=> (pscCnt_ff == 7'h00))
      else $error("Prescaler counted while not selected.");
   a_brg_from_tap: assert property (@(posedge clk) disable iff (!rst_n)
      brgTick |-> brgInTick && ((pscCnt_ff & tapMask) == tapMask))
      else $error("Generator ticked off a prescaler tap.");
   a_brg_period: assert property (@(posedge clk) disable iff (!rst_n)
      brgTick |-> (brgCnt_ff == period - 5'h01))
      else $error("Generator period does not match divider.");
   a_sclk_half: assert property (@(posedge clk) disable iff (!rst_n)
      (ioOutMode && brgTick) ##1 ioOutMode |-> (sclkOut_ff != $past(sclkOut_ff)))
      else $error("Clock output did not toggle at generator tick.");
   a_edge_swap: assert property (@(posedge clk) disable iff (!rst_n)
      (ioInMode && edgeSel_ff && pinRise) |-> ioTxStrobe && !ioRxStrobe)
      else $error("Clock input edge select not honoured.");
   a_uart_div16: assert property (@(posedge clk) disable iff (!rst_n)
      uartBitTick |-> transferClock && (divCnt_ff == UART_DIV_LAST) ##1 (divCnt_ff == 4'h0))
      else $error("Bit tick not on sixteenth transfer clock.");
   a_timer_toggle: assert property (@(posedge clk) disable iff (!rst_n)
      (timerCnt_ff == timerCompare_ff) |=> (timerFlop_ff != $past(timerFlop_ff)))
      else $error("Timer flop missed a compare match.");
   a_clear_reload: assert property (@(posedge clk) disable iff (!rst_n)
      (wrTbClr && (txCount_ff != 3'h0) && fifoEnable)
      |=> txBufValid && (txBufData == $past(txFifo_ff[0])))
      else $error("Buffer clear did not reload from FIFO.");
   a_clear_empty: assert property (@(posedge clk) disable iff (!rst_n)
      (wrTbClr && (txCount_ff == 3'h0)) |=> !txBufValid)
      else $error("Buffer clear did not set the empty flag.");
   a_fifo_gate: assert property (@(posedge clk) disable iff (!rst_n)
      !(wbuf_ff && cnfg_ff) |=> (txCount_ff == 3'h0))
      else $error("FIFO held data while disabled.");
   a_duplex_split: assert property (@(posedge clk) disable iff (!rst_n)
      (fifoEnable && (duplex_ff == DPX_FULL)) |-> (txCap == 3'h2) && (rxCap == 3'h2))
      else $error("Full duplex split is not two and two.");
   a_rx_double: assert property (@(posedge clk) disable iff (!rst_n)
      (!ioMode || ioClkIn_ff) |-> rxDouble)
      else $error("Receive not double buffered where required.");
endmodule
`default_nettype wire
